// >>> core/fpcvt_core.sv
`timescale 1ns/1ps
`include "fpcvt_consts.svh"

module fpcvt_core
  import fpcvt_pkg::*;
#(
  parameter int DEST_W = 5
)(
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  input  wire logic              issue_i,
  input  wire logic              cond_pass_i,
  input  wire logic              fp_undef_i,
  input  wire fpcvt_instr_t      instr_i,
  input  wire logic [DEST_W-1:0] dest_idx_i,
  input  wire logic [31:0]       src_m_i,
  input  wire logic [31:0]       src_d_i,
  input  wire logic [1:0]        rmode_i,
  input  wire logic              flush_zero_i,
  output logic      [31:0]       result_o,
  output logic      [DEST_W-1:0] dest_idx_o,
  output logic                   result_wr_o,
  output fpcvt_exc_t             exc_o,
  output logic                   unpredictable_o
);

  logic              form_int;
  logic              form_fixed;
  logic              form_half;
  logic              dir_bit;
  logic              to_int;
  logic              wide;
  logic              uns_fx;
  logic              uns_xf;
  logic [4:0]        imm5;
  logic [6:0]        frac_raw;
  logic [5:0]        fbits;
  logic              frac_neg;
  logic [31:0]       fx_src;
  logic [1:0]        fx_rm;
  logic [1:0]        xf_rm;
  logic [31:0]       fx_word;
  fpcvt_exc_t        fx_exc;
  logic [31:0]       xf_raw;
  logic              xf_neg;
  logic [31:0]       xf_mag;
  logic [4:0]        xf_lz;
  logic [31:0]       xf_norm;
  logic [24:0]       xf_sum;
  logic [9:0]        xf_exp;
  logic [31:0]       xf_word;
  logic              xf_inexact;
  logic [15:0]       hin;
  logic [4:0]        h_lz;
  logic [31:0]       h_norm;
  logic [31:0]       h2s_word;
  logic              h2s_invalid;
  logic              s_sgn;
  logic [7:0]        s_exp;
  logic [22:0]       s_frac;
  logic [9:0]        s_eh;
  logic [19:0]       s_tmp;
  fpcvt_shr_t        s_parts;
  logic              s_big;
  logic [15:0]       hout;
  fpcvt_exc_t        s2h_exc;
  logic [31:0]       s2h_word;
  logic              commit;
  logic [31:0]       result_ff;
  logic [31:0]       nxt_result;
  logic [DEST_W-1:0] dest_ff;
  logic [DEST_W-1:0] nxt_dest;
  logic              wr_ff;
  logic              nxt_wr;
  fpcvt_exc_t        exc_ff;
  fpcvt_exc_t        nxt_exc;
  logic              unpred_ff;
  logic              nxt_unpred;

  // ============================================================
  // Instruction field decode.
  always_comb begin
    form_int   = instr_i.form == FPCVT_FORM_INT;
    form_fixed = instr_i.form == FPCVT_FORM_FIXED;
    form_half  = instr_i.form == FPCVT_FORM_HALF;
    dir_bit    = instr_i.rounding_or_direction_bit;
    to_int     = instr_i.second_opcode_field[2];
    imm5       = {instr_i.fraction_field_high, instr_i.fraction_field_low};
    frac_raw   = (instr_i.size_select ? `FPCVT_FIX_WIDE : `FPCVT_FIX_NARROW)
                 - {2'b00, imm5};
    frac_neg   = form_fixed & frac_raw[6];
    wide       = form_int | instr_i.size_select;
    fbits      = form_int ? 6'h00 : frac_raw[5:0];
    uns_fx     = form_int ? ~instr_i.second_opcode_field[0]
                          : instr_i.unsigned_bit;
    uns_xf     = form_int ? ~dir_bit : instr_i.unsigned_bit;
    fx_src     = form_int ? src_m_i : src_d_i;
    if (!form_int || dir_bit) begin
      fx_rm = `FPCVT_RM_ZERO;
    end else begin
      fx_rm = rmode_i;
    end
    xf_rm      = form_int ? rmode_i : `FPCVT_RM_NEAREST;
  end

  // ============================================================
  // Float to integer or fixed point.
  fpcvt_to_fixed u_to_fixed (
    .op_i         (fx_src),
    .frac_bits_i  (fbits),
    .wide_i       (wide),
    .unsigned_i   (uns_fx),
    .rmode_i      (fx_rm),
    .flush_zero_i (flush_zero_i),
    .result_o     (fx_word),
    .exc_o        (fx_exc)
  );

  // ============================================================
  // Integer or fixed point to float.
  always_comb begin
    xf_raw     = wide ? fx_src
                      : {{16{~uns_xf & fx_src[15]}}, fx_src[15:0]};
    xf_neg     = ~uns_xf & xf_raw[31];
    xf_mag     = xf_neg ? -xf_raw : xf_raw;
    xf_lz      = fpcvt_lzc(xf_mag);
    xf_norm    = xf_mag << xf_lz;
    xf_sum     = {1'b0, xf_norm[31:8]}
                 + 25'(fpcvt_round_up(xf_rm, xf_neg, xf_norm[8], xf_norm[7],
                                      |xf_norm[6:0]));
    xf_exp     = `FPCVT_I2F_EXP_BASE - {5'h00, xf_lz} - {4'h0, fbits}
                 + {9'h000, xf_sum[24]};
    xf_inexact = |xf_norm[7:0];
    xf_word    = (xf_mag == 32'h0) ? 32'h0
                 : {xf_neg, xf_exp[7:0], xf_sum[22:0]};
  end

  // ============================================================
  // Half to single.
  always_comb begin
    hin         = instr_i.half_select ? src_m_i[31:16] : src_m_i[15:0];
    h_lz        = fpcvt_lzc({22'h0, hin[9:0]});
    h_norm      = {22'h0, hin[9:0]} << h_lz;
    h2s_invalid = 1'b0;
    if (hin[14:10] == `FPCVT_F16_EXP_MAX) begin
      h2s_invalid = (hin[9:0] != 10'h0) & ~hin[9];
      h2s_word    = (hin[9:0] == 10'h0) ? {hin[15], `FPCVT_F32_EXP_MAX, 23'h0}
                    : {hin[15], `FPCVT_F32_EXP_MAX, 1'b1, hin[8:0], 13'h0};
    end else if (hin[14:10] == 5'h00) begin
      h2s_word    = (hin[9:0] == 10'h0) ? {hin[15], 31'h0}
                    : {hin[15], `FPCVT_H2S_SUB_EXP - {3'b000, h_lz},
                       h_norm[30:8]};
    end else begin
      h2s_word    = {hin[15], 8'({5'h00, hin[14:10]} + `FPCVT_EXP_DELTA),
                     hin[9:0], 13'h0};
    end
  end

  // ============================================================
  // Single to half.
  always_comb begin
    s_sgn   = src_m_i[31];
    s_exp   = src_m_i[30:23];
    s_frac  = src_m_i[22:0];
    s_eh    = {2'b00, s_exp} - `FPCVT_EXP_DELTA;
    s_tmp   = {s_eh, s_frac[22:13]}
              + 20'(fpcvt_round_up(rmode_i, s_sgn, s_frac[13], s_frac[12],
                                   |s_frac[11:0]));
    s_parts = fpcvt_shr({s_exp != 8'h00, s_frac},
                        `FPCVT_S2H_SUB_SHIFT - {1'b0, s_exp}
                        - {8'h00, s_exp == 8'h00});
    s_big   = (rmode_i == `FPCVT_RM_NEAREST) ||
              (rmode_i == `FPCVT_RM_PLUS && !s_sgn) ||
              (rmode_i == `FPCVT_RM_MINUS && s_sgn);
    s2h_exc = '0;
    if (s_exp == `FPCVT_F32_EXP_MAX) begin
      s2h_exc.invalid = (s_frac != 23'h0) & ~s_frac[22];
      hout = (s_frac == 23'h0) ? {s_sgn, `FPCVT_F16_EXP_MAX, 10'h0}
             : {s_sgn, `FPCVT_F16_EXP_MAX, 1'b1, s_frac[21:13]};
    end else if (s_exp == 8'h00 && (s_frac == 23'h0 || flush_zero_i)) begin
      s2h_exc.in_denormal = s_frac != 23'h0;
      hout = {s_sgn, 15'h0};
    end else if (!s_eh[9] && s_eh != 10'h0) begin
      if ($signed(s_tmp[19:10]) >= $signed(`FPCVT_F16_EXP_TOP)) begin
        s2h_exc.overflow = 1'b1;
        s2h_exc.inexact  = 1'b1;
        hout = s_big ? {s_sgn, `FPCVT_F16_EXP_MAX, 10'h0}
                     : {s_sgn, 5'h1e, 10'h3ff};
      end else begin
        s2h_exc.inexact = |s_frac[12:0];
        hout = {s_sgn, s_tmp[14:0]};
      end
    end else begin
      s2h_exc.inexact   = s_parts.guard | s_parts.sticky;
      s2h_exc.underflow = s_parts.guard | s_parts.sticky;
      hout = {s_sgn, 4'h0, 11'({1'b0, s_parts.whole[9:0]}
             + 11'(fpcvt_round_up(rmode_i, s_sgn, s_parts.whole[0],
                                  s_parts.guard, s_parts.sticky)))};
    end
    s2h_word = instr_i.half_select ? {hout, src_d_i[15:0]}
                                   : {src_d_i[31:16], hout};
  end

  // ============================================================
  // Result and flag registers.
  always_comb begin
    commit     = issue_i & cond_pass_i & ~fp_undef_i;
    nxt_wr     = commit & ~frac_neg;
    nxt_unpred = commit & frac_neg;
    nxt_dest   = commit ? dest_idx_i : dest_ff;
    nxt_result = result_ff;
    nxt_exc    = '0;
    if (nxt_wr) begin
      if (form_half) begin
        nxt_result = dir_bit ? s2h_word : h2s_word;
        nxt_exc    = dir_bit ? s2h_exc : fpcvt_exc_t'{1'b0, h2s_invalid,
                                                      1'b0, 1'b0, 1'b0};
      end else if (form_fixed ? dir_bit : to_int) begin
        nxt_result = fx_word;
        nxt_exc    = fx_exc;
      end else begin
        nxt_result = xf_word;
        nxt_exc    = '{1'b0, 1'b0, 1'b0, 1'b0, xf_inexact};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      result_ff <= 32'h0;
      dest_ff   <= '0;
      wr_ff     <= 1'b0;
      exc_ff    <= '0;
      unpred_ff <= 1'b0;
    end else begin
      result_ff <= nxt_result;
      dest_ff   <= nxt_dest;
      wr_ff     <= nxt_wr;
      exc_ff    <= nxt_exc;
      unpred_ff <= nxt_unpred;
    end
  end

  assign result_o        = result_ff;
  assign dest_idx_o      = dest_ff;
  assign result_wr_o     = wr_ff;
  assign exc_o           = exc_ff;
  assign unpredictable_o = unpred_ff;

  // ============================================================
  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_commit;
    issue_i && cond_pass_i && !fp_undef_i && !frac_neg;
  endsequence

  property p_commit_write;
    s_commit |=> result_wr_o && dest_idx_o == $past(dest_idx_i);
  endproperty
  a_commit_write: assert property (p_commit_write)
    else $error("Qualified instruction did not write.");

  property p_no_write;
    !(issue_i && cond_pass_i && !fp_undef_i) |=> !result_wr_o && exc_o == '0;
  endproperty
  a_no_write: assert property (p_no_write)
    else $error("Write or flags without a qualified instruction.");

  property p_unpred;
    issue_i && cond_pass_i && !fp_undef_i && frac_neg
      |=> unpredictable_o && !result_wr_o;
  endproperty
  a_unpred: assert property (p_unpred)
    else $error("Negative fraction count not refused.");

  property p_uns_negative;
    s_commit ##0 (form_int && to_int && !instr_i.second_opcode_field[0]
                  && src_m_i[31] && src_m_i[30:23] != 8'hff)
      |=> result_o == 32'h0;
  endproperty
  a_uns_negative: assert property (p_uns_negative)
    else $error("Unsigned conversion of negative value not zero.");

  property p_trunc_int;
    s_commit ##0 (form_int && to_int && dir_bit && !src_m_i[31]
                  && src_m_i[30:23] >= 8'h7f && src_m_i[30:23] <= 8'h96)
      |=> result_o == $past(32'({1'b1, src_m_i[22:0]})
                            >> (8'h96 - src_m_i[30:23]));
  endproperty
  a_trunc_int: assert property (p_trunc_int)
    else $error("Truncating integer result mismatch.");

  property p_i2f_sign;
    s_commit ##0 (form_int && !to_int && dir_bit && src_m_i[31])
      |=> result_o[31];
  endproperty
  a_i2f_sign: assert property (p_i2f_sign)
    else $error("Signed negative integer gave positive float.");

  property p_no_range_flags;
    s_commit ##0 !form_half |=> !exc_o.overflow && !exc_o.underflow;
  endproperty
  a_no_range_flags: assert property (p_no_range_flags)
    else $error("Range flag from integer or fixed conversion.");

  property p_narrow_ext;
    s_commit ##0 (form_fixed && dir_bit && !instr_i.size_select)
      |=> result_o[31:16] == ($past(instr_i.unsigned_bit) ? 16'h0
                              : {16{result_o[15]}});
  endproperty
  a_narrow_ext: assert property (p_narrow_ext)
    else $error("Narrow fixed result badly extended.");

  property p_low_bits_only;
    s_commit ##0 (form_fixed && !dir_bit && !instr_i.size_select
                  && src_d_i[15:0] == 16'h0) |=> result_o == 32'h0;
  endproperty
  a_low_bits_only: assert property (p_low_bits_only)
    else $error("Upper source bits affected fixed conversion.");

  property p_half_keep;
    s_commit ##0 (form_half && dir_bit)
      |=> ($past(instr_i.half_select) ? result_o[15:0] == $past(src_d_i[15:0])
           : result_o[31:16] == $past(src_d_i[31:16]));
  endproperty
  a_half_keep: assert property (p_half_keep)
    else $error("Unselected half of destination changed.");

  property p_h2s_exp;
    s_commit ##0 (form_half && !dir_bit && !instr_i.half_select
                  && src_m_i[14:10] != 5'h00 && src_m_i[14:10] != 5'h1f)
      |=> result_o[30:23] == $past(8'({3'b000, src_m_i[14:10]}) + 8'h70);
  endproperty
  a_h2s_exp: assert property (p_h2s_exp)
    else $error("Half to single exponent wrong.");

endmodule // fpcvt_core

// >>> core/fpcvt_consts.svh
`ifndef FPCVT_CONSTS_SVH
`define FPCVT_CONSTS_SVH

// ============================================================
// Rounding mode encodings.
`define FPCVT_RM_NEAREST 2'h0
`define FPCVT_RM_PLUS 2'h1
`define FPCVT_RM_MINUS 2'h2
`define FPCVT_RM_ZERO 2'h3

// ============================================================
// Format and exponent constants.
`define FPCVT_F32_EXP_MAX 8'hff
`define FPCVT_F16_EXP_MAX 5'h1f
`define FPCVT_F16_EXP_TOP 10'h01f
`define FPCVT_EXP_DELTA 10'h070
`define FPCVT_F2X_SHIFT 11'h096
`define FPCVT_F2X_BIG 11'h028
`define FPCVT_I2F_EXP_BASE 10'h09e
`define FPCVT_H2S_SUB_EXP 8'h86
`define FPCVT_S2H_SUB_SHIFT 9'h07e
`define FPCVT_FIX_NARROW 7'h10
`define FPCVT_FIX_WIDE 7'h20

`endif

// >>> core/fpcvt_pkg.sv
`include "fpcvt_consts.svh"

package fpcvt_pkg;

  // ============================================================
  // Types.
  typedef enum logic [1:0] {
    FPCVT_FORM_INT   = 2'b00,
    FPCVT_FORM_FIXED = 2'b01,
    FPCVT_FORM_HALF  = 2'b10
  } fpcvt_form_t;

  typedef struct packed {
    fpcvt_form_t form;
    logic [2:0]  second_opcode_field;
    logic        rounding_or_direction_bit;
    logic        unsigned_bit;
    logic        size_select;
    logic [3:0]  fraction_field_high;
    logic        fraction_field_low;
    logic        half_select;
  } fpcvt_instr_t;

  typedef struct packed {
    logic in_denormal;
    logic invalid;
    logic overflow;
    logic underflow;
    logic inexact;
  } fpcvt_exc_t;

  typedef struct packed {
    logic [23:0] whole;
    logic        guard;
    logic        sticky;
  } fpcvt_shr_t;

  // ============================================================
  // Shared arithmetic.
  function automatic fpcvt_shr_t fpcvt_shr(input logic [23:0] m,
                                           input logic [8:0]  n);
    logic [71:0] ext;
    fpcvt_shr_t  r;
    ext = {m, 48'h0} >> n;
    if (n > 9'h030) begin
      r = '{whole: 24'h0, guard: 1'b0, sticky: |m};
    end else begin
      r = '{whole: ext[71:48], guard: ext[47], sticky: |ext[46:0]};
    end
    return r;
  endfunction

  function automatic logic fpcvt_round_up(input logic [1:0] rm,
                                          input logic sign,
                                          input logic lsb,
                                          input logic guard,
                                          input logic sticky);
    logic r;
    case (rm)
      `FPCVT_RM_NEAREST: r = guard & (sticky | lsb);
      `FPCVT_RM_PLUS:    r = ~sign & (guard | sticky);
      `FPCVT_RM_MINUS:   r = sign & (guard | sticky);
      default:           r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [4:0] fpcvt_lzc(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        r = 5'(31 - i);
      end
    end
    return r;
  endfunction

endpackage

// >>> core/fpcvt_to_fixed.sv
`timescale 1ns/1ps
`include "fpcvt_consts.svh"

module fpcvt_to_fixed
  import fpcvt_pkg::*;
(
  input  wire logic [31:0] op_i,
  input  wire logic [5:0]  frac_bits_i,
  input  wire logic        wide_i,
  input  wire logic        unsigned_i,
  input  wire logic [1:0]  rmode_i,
  input  wire logic        flush_zero_i,
  output logic      [31:0] result_o,
  output fpcvt_exc_t       exc_o
);

  logic               sign;
  logic [7:0]         exp_eff;
  logic [23:0]        mant;
  logic signed [10:0] sh;
  fpcvt_shr_t         parts;
  logic               inc;
  logic [63:0]        mag;
  logic [63:0]        lim;
  logic [63:0]        val;
  logic               ovf;

  // ============================================================
  // Float to integer or fixed point.
  always_comb begin
    sign    = op_i[31];
    exp_eff = (op_i[30:23] == 8'h00) ? 8'h01 : op_i[30:23];
    mant    = {op_i[30:23] != 8'h00, op_i[22:0]};
    exc_o   = '0;
    sh      = $signed({3'b000, exp_eff}) - $signed(`FPCVT_F2X_SHIFT)
              + $signed({5'b00000, frac_bits_i});
    parts   = fpcvt_shr(mant, (sh < 0) ? 9'(-sh) : 9'h000);
    inc     = (sh < 0) && fpcvt_round_up(rmode_i, sign, parts.whole[0],
                                         parts.guard, parts.sticky);
    if (sh < 0) begin
      mag = 64'(parts.whole) + 64'(inc);
    end else begin
      mag = 64'(mant) << sh[5:0];
    end
    if (unsigned_i) begin
      lim = wide_i ? 64'hffff_ffff : 64'h0000_ffff;
    end else begin
      lim = (wide_i ? 64'h7fff_ffff : 64'h0000_7fff) + 64'(sign);
    end
    ovf = (sh > $signed(`FPCVT_F2X_BIG)) || (mag > lim);
    if (op_i[30:23] == `FPCVT_F32_EXP_MAX && op_i[22:0] != 23'h0) begin
      exc_o.invalid = 1'b1;
      val           = 64'h0;
    end else if (flush_zero_i && op_i[30:23] == 8'h00 &&
                 op_i[22:0] != 23'h0) begin
      exc_o.in_denormal = 1'b1;
      val               = 64'h0;
    end else if (ovf || op_i[30:23] == `FPCVT_F32_EXP_MAX) begin
      exc_o.invalid = 1'b1;
      val           = (unsigned_i && sign) ? 64'h0 :
                      (sign ? -lim : lim);
    end else if (unsigned_i && sign && mag != 64'h0) begin
      exc_o.invalid = 1'b1;
      val           = 64'h0;
    end else begin
      exc_o.inexact = (sh < 0) && (parts.guard | parts.sticky);
      val           = sign ? -mag : mag;
    end
    result_o = wide_i ? val[31:0] :
               {{16{~unsigned_i & val[15]}}, val[15:0]};
  end

endmodule // fpcvt_to_fixed

// >>> tb/fpcvt_rf_model.sv
`timescale 1ns/1ps

// ============================================================
// Register file seen by the converter: the destination register is
// read back as the operand and rewritten when a result is committed.
module fpcvt_rf_model
  import fpcvt_pkg::*;
#(
  parameter int DEST_W = 5
)(
  input  wire logic              clk_i,
  input  wire logic [DEST_W-1:0] rd_idx_i,
  output logic      [31:0]       rd_data_o,
  input  wire logic              wr_i,
  input  wire logic [DEST_W-1:0] wr_idx_i,
  input  wire logic [31:0]       wr_data_i
);
  logic [31:0] regs [2**DEST_W];

  initial begin
    for (int i = 0; i < 2**DEST_W; i++) begin
      regs[i] = 32'h0;
    end
  end

  // The destination register doubles as the operand register.
  assign rd_data_o = regs[rd_idx_i];

  // Only committed results reach the register file.
  always @(posedge clk_i) begin
    if (wr_i === 1'b1) begin
      regs[wr_idx_i] <= wr_data_i;
    end
  end
endmodule // fpcvt_rf_model

// >>> tb/fp_format_converter_tb.sv
`timescale 1ns/1ps

module fp_format_converter_tb
  import fpcvt_pkg::*;
;
  // ============================================================
  // Stimulus and observed signals.
  logic         clk_i = 1'b0;
  logic         srst_i = 1'b1;
  logic         issue_i = 1'b0;
  logic         cond_pass_i = 1'b1;
  logic         fp_undef_i = 1'b0;
  fpcvt_instr_t instr_i = '0;
  logic [4:0]   dest_idx_i = 5'h00;
  logic [31:0]  src_m_i = 32'h0;
  logic [31:0]  src_d_i;
  logic [1:0]   rmode_i = 2'h0;
  logic         flush_zero_i = 1'b0;
  logic [31:0]  result_o;
  logic [4:0]   dest_idx_o;
  logic         result_wr_o;
  fpcvt_exc_t   exc_o;
  logic         unpredictable_o;
  int           mismatches = 0;
  int           n_tests = 0;
  int           cycles = 0;

  always #10 clk_i = ~clk_i;

  fpcvt_core #(.DEST_W(5)) i_dut (
    .clk_i(clk_i), .srst_i(srst_i), .issue_i(issue_i),
    .cond_pass_i(cond_pass_i), .fp_undef_i(fp_undef_i),
    .instr_i(instr_i), .dest_idx_i(dest_idx_i), .src_m_i(src_m_i),
    .src_d_i(src_d_i), .rmode_i(rmode_i), .flush_zero_i(flush_zero_i),
    .result_o(result_o), .dest_idx_o(dest_idx_o),
    .result_wr_o(result_wr_o), .exc_o(exc_o),
    .unpredictable_o(unpredictable_o));

  fpcvt_rf_model #(.DEST_W(5)) i_rf (
    .clk_i(clk_i), .rd_idx_i(dest_idx_i), .rd_data_o(src_d_i),
    .wr_i(result_wr_o), .wr_idx_i(dest_idx_o), .wr_data_i(result_o));

  // ============================================================
  // Shared tasks.
  task automatic final_report();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic fpcvt_instr_t mk(input fpcvt_form_t f,
    input logic [2:0] opc, input logic rb, input logic u, input logic sx,
    input logic [4:0] imm, input logic hs);
    return '{f, opc, rb, u, sx, imm[4:1], imm[0], hs};
  endfunction

  task automatic load(input logic [4:0] d, input logic [31:0] v);
    @(posedge clk_i);
    #1;
    i_rf.regs[d] = v;
  endtask

  task automatic op(input fpcvt_instr_t ins, input logic [4:0] d,
    input logic [31:0] m, input logic [31:0] er, input logic [4:0] ee);
    @(posedge clk_i);
    #1;
    issue_i = 1'b1;
    instr_i = ins;
    dest_idx_i = d;
    src_m_i = m;
    @(posedge clk_i);
    #1;
    issue_i = 1'b0;
    check("write strobe", 32'h1, {31'h0, result_wr_o});
    check("result", er, result_o);
    check("dest index", {27'h0, d}, {27'h0, dest_idx_o});
    check("flags", {27'h0, ee}, {27'h0, exc_o});
  endtask

  // ============================================================
  // Scenarios.
  task automatic t_int();
    rmode_i = 2'h0;
    op(mk(FPCVT_FORM_INT, 3'h5, 1'b1, 1'b0, 1'b0, 5'h00, 1'b0), 5'h01,
       32'hc0200000, 32'hfffffffe, 5'h01);
    op(mk(FPCVT_FORM_INT, 3'h4, 1'b0, 1'b0, 1'b0, 5'h00, 1'b0), 5'h01,
       32'h40200000, 32'h00000002, 5'h01);
    rmode_i = 2'h1;
    op(mk(FPCVT_FORM_INT, 3'h4, 1'b0, 1'b0, 1'b0, 5'h00, 1'b0), 5'h01,
       32'h40200000, 32'h00000003, 5'h01);
    op(mk(FPCVT_FORM_INT, 3'h4, 1'b1, 1'b0, 1'b0, 5'h00, 1'b0), 5'h01,
       32'h40200000, 32'h00000002, 5'h01);
    op(mk(FPCVT_FORM_INT, 3'h4, 1'b1, 1'b0, 1'b0, 5'h00, 1'b0), 5'h01,
       32'hc0200000, 32'h00000000, 5'h08);
    op(mk(FPCVT_FORM_INT, 3'h0, 1'b1, 1'b0, 1'b0, 5'h00, 1'b0), 5'h02,
       32'hffffffff, 32'hbf800000, 5'h00);
    rmode_i = 2'h3;
    op(mk(FPCVT_FORM_INT, 3'h0, 1'b0, 1'b0, 1'b0, 5'h00, 1'b0), 5'h02,
       32'hffffffff, 32'h4f7fffff, 5'h01);
    op(mk(FPCVT_FORM_INT, 3'h5, 1'b1, 1'b0, 1'b0, 5'h00, 1'b0), 5'h02,
       32'h7fc00000, 32'h00000000, 5'h08);
    flush_zero_i = 1'b1;
    op(mk(FPCVT_FORM_INT, 3'h5, 1'b1, 1'b0, 1'b0, 5'h00, 1'b0), 5'h02,
       32'h00000001, 32'h00000000, 5'h10);
    flush_zero_i = 1'b0;
  endtask

  task automatic t_fixed();
    rmode_i = 2'h2;
    load(5'h03, 32'hbfc40000);
    op(mk(FPCVT_FORM_FIXED, 3'h0, 1'b1, 1'b0, 1'b0, 5'h0c, 1'b0), 5'h03,
       32'h3f800000, 32'hffffffe8, 5'h01);
    load(5'h04, 32'h3fc40000);
    op(mk(FPCVT_FORM_FIXED, 3'h0, 1'b1, 1'b1, 1'b1, 5'h1c, 1'b0), 5'h04,
       32'h0, 32'h00000018, 5'h01);
    load(5'h05, 32'habcdfe80);
    op(mk(FPCVT_FORM_FIXED, 3'h0, 1'b0, 1'b0, 1'b0, 5'h08, 1'b0), 5'h05,
       32'h0, 32'hbfc00000, 5'h00);
    load(5'h09, 32'hffff0000);
    op(mk(FPCVT_FORM_FIXED, 3'h0, 1'b0, 1'b0, 1'b0, 5'h00, 1'b0), 5'h09,
       32'h0, 32'h00000000, 5'h00);
    rmode_i = 2'h1;
    load(5'h06, 32'h01000001);
    op(mk(FPCVT_FORM_FIXED, 3'h0, 1'b0, 1'b1, 1'b1, 5'h1f, 1'b0), 5'h06,
       32'h0, 32'h4b000000, 5'h01);
    @(posedge clk_i);
    #1;
    issue_i = 1'b1;
    instr_i = mk(FPCVT_FORM_FIXED, 3'h0, 1'b1, 1'b0, 1'b0, 5'h11, 1'b0);
    @(posedge clk_i);
    #1;
    issue_i = 1'b0;
    check("refused fraction", 32'h1, {31'h0, unpredictable_o});
    check("refused write", 32'h0, {31'h0, result_wr_o});
  endtask

  task automatic t_half();
    rmode_i = 2'h0;
    op(mk(FPCVT_FORM_HALF, 3'h0, 1'b0, 1'b0, 1'b0, 5'h00, 1'b1), 5'h08,
       32'h3c001234, 32'h3f800000, 5'h00);
    op(mk(FPCVT_FORM_HALF, 3'h0, 1'b0, 1'b0, 1'b0, 5'h00, 1'b0), 5'h08,
       32'h4000c000, 32'hc0000000, 5'h00);
    load(5'h07, 32'h12345678);
    op(mk(FPCVT_FORM_HALF, 3'h0, 1'b1, 1'b0, 1'b0, 5'h00, 1'b0), 5'h07,
       32'h3f800000, 32'h12343c00, 5'h00);
    op(mk(FPCVT_FORM_HALF, 3'h0, 1'b1, 1'b0, 1'b0, 5'h00, 1'b1), 5'h07,
       32'h3f800000, 32'h3c003c00, 5'h00);
    op(mk(FPCVT_FORM_HALF, 3'h0, 1'b1, 1'b0, 1'b0, 5'h00, 1'b0), 5'h07,
       32'h47800000, 32'h3c007c00, 5'h05);
  endtask

  task automatic t_refuse();
    @(posedge clk_i);
    #1;
    issue_i = 1'b1;
    cond_pass_i = 1'b0;
    instr_i = mk(FPCVT_FORM_INT, 3'h5, 1'b1, 1'b0, 1'b0, 5'h00, 1'b0);
    src_m_i = 32'h40200000;
    @(posedge clk_i);
    #1;
    cond_pass_i = 1'b1;
    fp_undef_i = 1'b1;
    check("failed condition", 32'h0, {31'h0, result_wr_o});
    check("refused flags", 32'h0, {27'h0, exc_o});
    @(posedge clk_i);
    #1;
    issue_i = 1'b0;
    fp_undef_i = 1'b0;
    check("undefined check", 32'h0, {31'h0, result_wr_o});
    check("held result", 32'h3c007c00, result_o);
  endtask

  // ============================================================
  // Main sequence and hang guard.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    repeat (4) @(posedge clk_i);
    #1;
    srst_i = 1'b0;
    check("reset result", 32'h0, result_o);
    check("reset strobe", 32'h0, {31'h0, result_wr_o});
    t_int();
    t_fixed();
    t_half();
    t_refuse();
    final_report();
  end
endmodule // fp_format_converter_tb
